// ===== hdl/los_and_error_count_control.sv
// Loss-of-signal detection and error counter control with an AHB-Lite register slave
//
// Our own choice: register access over AHB-Lite.
`timescale 1ns/1ps
`include "los_defs.svh"

module los_and_error_count_control #(
  parameter int unsigned COUNT_PERIOD_CYCLES = `COUNT_PERIOD_CYCLES
) (
  // Clock, reset, enable
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              hce,
  // AHB-Lite slave
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic      [31:0]       hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  // Line datapath
  input  wire los_pkg::link_in_s link_in,
  output los_pkg::link_out_s     link_out,
  // Interrupt
  output logic                   irq
);

  // ========================================================================
  // State
  typedef struct packed {
    los_pkg::bus_phase_e        phase;
    logic [5:0]                 addr_idx;
    logic                       addr_ok;
    logic [31:0]                rdata;
    logic                       ready;
    logic [7:0]                 monitor_gain_config;
    logic [7:0]                 loss_detect_config;
    logic [7:0]                 error_count_control;
    logic [`IRQ_WIDTH-1:0]      irq_status;
    logic [`IRQ_WIDTH-1:0]      irq_mask;
    logic                       irq;
    logic                       trig_prev;
    logic [15:0]                run_count;
    logic [7:0]                 error_count_high;
    logic [7:0]                 error_count_low;
    logic [27:0]                tick;
    logic [10:0]                line_low_run;
    logic [10:0]                tx_low_run;
    los_pkg::link_out_s         out;
  } state_s;

  state_s s;
  state_s next_s;

  // ========================================================================
  // Combinational update
  always_comb begin
    logic [1:0]             inc;
    logic [16:0]            sum;
    logic [10:0]            line_n;
    logic [10:0]            tx_n;
    logic                   update;
    logic [`IRQ_WIDTH-1:0]  irq_set;
    logic [`IRQ_WIDTH-1:0]  irq_clr;
    logic [31:0]            rd;
    logic [7:0]             wd;
    los_pkg::count_source_e src;

    next_s  = s;
    inc     = 2'b00;
    sum     = 17'h00000;
    irq_set = '0;
    irq_clr = '0;
    rd      = 32'h00000000;
    wd      = hwdata[7:0];
    update  = 1'b0;
    line_n  = 11'h000;
    tx_n    = 11'h000;
    src     = los_pkg::count_source_e'(s.error_count_control[`EC_SRC_HI:`EC_SRC_LO]);

    // Line loss: N consecutive low pulse intervals
    line_n = s.loss_detect_config[`LD_CRITERIA] ? `LINE_LOSS_N_ALT
                                                : `LINE_LOSS_N_STD;
    if (link_in.line_pulse) begin
      if (link_in.line_amp_low) begin
        if (s.line_low_run != 11'h7FF) begin
          next_s.line_low_run = s.line_low_run + 11'h001;
        end
        if (s.line_low_run + 11'h001 >= line_n && !s.out.line_signal_loss) begin
          next_s.out.line_signal_loss = 1'b1;
          irq_set[`IRQ_LINE_LOSS]     = 1'b1;
        end
      end else begin
        next_s.line_low_run         = 11'h000;
        next_s.out.line_signal_loss = 1'b0;
      end
    end

    // Transmit loss: low for the selected period, cleared by one good pulse
    case (s.loss_detect_config[`LD_TX_PER_HI:`LD_TX_PER_LO])
      2'b00:   tx_n = `TX_LOSS_N_SHORT;
      2'b01:   tx_n = `TX_LOSS_N_MID;
      default: tx_n = `TX_LOSS_N_LONG;
    endcase
    if (link_in.tx_pulse) begin
      if (link_in.tx_amp_low) begin
        if (s.tx_low_run != 11'h7FF) begin
          next_s.tx_low_run = s.tx_low_run + 11'h001;
        end
        if (s.tx_low_run + 11'h001 >= tx_n && !s.out.transmit_signal_loss) begin
          next_s.out.transmit_signal_loss = 1'b1;
          irq_set[`IRQ_TX_LOSS]           = 1'b1;
        end
      end else begin
        next_s.tx_low_run               = 11'h000;
        next_s.out.transmit_signal_loss = 1'b0;
      end
    end

    // Event selection
    case (src)
      los_pkg::src_off:       inc = 2'b00;
      los_pkg::src_line_bpv:  inc = {1'b0, link_in.line_bipolar_violation};
      los_pkg::src_line_exz:  inc = {1'b0, link_in.line_excess_zeros};
      los_pkg::src_line_both: inc = {1'b0, link_in.line_bipolar_violation}
                                  + {1'b0, link_in.line_excess_zeros};
      los_pkg::src_sys_bpv:   inc = {1'b0, link_in.system_bipolar_violation};
      los_pkg::src_sys_exz:   inc = {1'b0, link_in.system_excess_zeros};
      los_pkg::src_sys_both:  inc = {1'b0, link_in.system_bipolar_violation}
                                  + {1'b0, link_in.system_excess_zeros};
      default:                inc = {1'b0, link_in.pattern_error};
    endcase

    // Update trigger: timed or manual rising edge
    next_s.trig_prev = s.error_count_control[`EC_UPD_TRIG];
    if (s.error_count_control[`EC_UPD_MODE]) begin
      if (s.tick >= 28'(COUNT_PERIOD_CYCLES - 1)) begin
        next_s.tick = 28'h0000000;
        update      = 1'b1;
      end else begin
        next_s.tick = s.tick + 28'h0000001;
      end
    end else begin
      next_s.tick = 28'h0000000;
      update      = s.error_count_control[`EC_UPD_TRIG] && !s.trig_prev;
    end

    // Saturating counter; events in the update cycle start the new count
    if (update) begin
      next_s.error_count_high = s.run_count[15:8];
      next_s.error_count_low  = s.run_count[7:0];
      next_s.run_count        = {14'h0000, inc};
      irq_set[`IRQ_COUNT_UPDATE] = 1'b1;
    end else begin
      sum = {1'b0, s.run_count} + {15'h0000, inc};
      next_s.run_count = sum[16] ? 16'hFFFF : sum[15:0];
    end

    // Self-clearing insert requests
    next_s.out.violation_insert_pulse = 1'b0;
    next_s.out.error_insert_pulse     = 1'b0;
    if (s.error_count_control[`EC_VIOL_INS] && link_in.tx_mark) begin
      next_s.out.violation_insert_pulse             = 1'b1;
      next_s.error_count_control[`EC_VIOL_INS]      = 1'b0;
    end
    if (s.error_count_control[`EC_SINGLE_ERROR_INSERT] && link_in.pattern_bit) begin
      next_s.out.error_insert_pulse                 = 1'b1;
      next_s.error_count_control[`EC_SINGLE_ERROR_INSERT]       = 1'b0;
    end

    // Bus data phase: writes land at its end, after hardware clears
    next_s.ready = 1'b1;
    if (s.phase == los_pkg::ph_write && s.addr_ok) begin
      if (s.addr_idx == `IDX_MONITOR_GAIN) begin
        next_s.monitor_gain_config = {6'h00, wd[1:0]};
      end else if (s.addr_idx == `IDX_LOSS_DETECT) begin
        next_s.loss_detect_config = wd;
      end else if (s.addr_idx == `IDX_ERROR_CONTROL) begin
        // Only a 0-to-1 write arms; while armed the bit follows hardware, so no double error
        if (s.error_count_control[`EC_SINGLE_ERROR_INSERT]) begin
          wd[`EC_SINGLE_ERROR_INSERT] = next_s.error_count_control[`EC_SINGLE_ERROR_INSERT];
        end
        next_s.error_count_control = wd;
      end else if (s.addr_idx == `IDX_IRQ_STATUS) begin
        irq_clr = wd[`IRQ_WIDTH-1:0];
      end else if (s.addr_idx == `IDX_IRQ_MASK) begin
        next_s.irq_mask = wd[`IRQ_WIDTH-1:0];
      end
    end

    // Read data is taken one cycle after the address so a preceding write shows
    if (s.phase == los_pkg::ph_read) begin
      if (!s.addr_ok) begin
        rd = 32'h00000000;
      end else if (s.addr_idx == `IDX_MONITOR_GAIN) begin
        rd = {24'h000000, s.monitor_gain_config};
      end else if (s.addr_idx == `IDX_LOSS_DETECT) begin
        rd = {24'h000000, s.loss_detect_config};
      end else if (s.addr_idx == `IDX_ERROR_CONTROL) begin
        rd = {24'h000000, s.error_count_control};
      end else if (s.addr_idx == `IDX_IRQ_STATUS) begin
        rd = {29'h00000000, s.irq_status};
      end else if (s.addr_idx == `IDX_IRQ_MASK) begin
        rd = {29'h00000000, s.irq_mask};
      end else if (s.addr_idx == `IDX_COUNT_HIGH) begin
        rd = {24'h000000, s.error_count_high};
      end else if (s.addr_idx == `IDX_COUNT_LOW) begin
        rd = {24'h000000, s.error_count_low};
      end else if (s.addr_idx == `IDX_LOSS_STATUS) begin
        rd = {30'h00000000, s.out.transmit_signal_loss, s.out.line_signal_loss};
      end
      next_s.rdata = rd;
      next_s.phase = los_pkg::ph_idle;
    end else if (s.phase == los_pkg::ph_write) begin
      next_s.phase = los_pkg::ph_idle;
    end

    // Address phase
    if (hsel && hready && htrans[1] && s.phase != los_pkg::ph_read) begin
      next_s.addr_idx = haddr[7:2];
      next_s.addr_ok  = (haddr[31:8] == 24'h000000) && (hsize == 3'b010);
      if (hwrite) begin
        next_s.phase = los_pkg::ph_write;
      end else begin
        next_s.phase = los_pkg::ph_read;
        next_s.ready = 1'b0;
      end
    end

    // Sticky status: a set in the clearing cycle wins
    next_s.irq_status = (s.irq_status & ~irq_clr) | irq_set;
    next_s.irq        = |(next_s.irq_status & next_s.irq_mask);

    // Settings toward the datapath
    next_s.out.monitor_gain_sel         = next_s.monitor_gain_config[1:0];
    next_s.out.loss_criteria_sel        = next_s.loss_detect_config[`LD_CRITERIA];
    // Threshold code mapping is in the analogue comparator
    next_s.out.line_loss_amplitude_sel  =
      next_s.loss_detect_config[`LD_LINE_AMP_HI:`LD_LINE_AMP_LO];
    next_s.out.tx_loss_amplitude_sel    =
      next_s.loss_detect_config[`LD_TX_AMP_HI:`LD_TX_AMP_LO];
    next_s.out.excess_zero_standard_sel = next_s.error_count_control[`EC_EXZ_STD];
  end

  // ========================================================================
  // Registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s                                  <= '0;
      s.phase                            <= los_pkg::ph_idle;
      s.ready                            <= 1'b1;
      s.monitor_gain_config              <= `RST_MONITOR_GAIN;
      s.loss_detect_config               <= `RST_LOSS_DETECT;
      s.error_count_control              <= `RST_ERROR_CONTROL;
      s.out.line_loss_amplitude_sel      <= 3'b001;
      s.out.tx_loss_amplitude_sel        <= 2'b01;
    end else if (hce) begin
      s <= next_s;
    end
  end

  // ========================================================================
  // Outputs
  assign hrdata    = s.rdata;
  assign hreadyout = s.ready;
  assign hresp     = 1'b0;
  assign link_out  = s.out;
  assign irq       = s.irq;

endmodule : los_and_error_count_control

// ===== hdl/los_defs.svh
// Register indices, field positions, reset values and timing counts for the loss/error block
`ifndef LOS_DEFS_SVH
`define LOS_DEFS_SVH

// ==========================================================================
// Register indices (byte address is four times the index)
`define IDX_MONITOR_GAIN    6'h0C
`define IDX_LOSS_DETECT     6'h0D
`define IDX_ERROR_CONTROL   6'h0E
`define IDX_IRQ_STATUS      6'h20
`define IDX_IRQ_MASK        6'h21
`define IDX_COUNT_HIGH      6'h22
`define IDX_COUNT_LOW       6'h23
`define IDX_LOSS_STATUS     6'h24

// ==========================================================================
// Reset values
`define RST_MONITOR_GAIN    8'h00
`define RST_LOSS_DETECT     8'h15
`define RST_ERROR_CONTROL   8'h00

// ==========================================================================
// Field positions, loss_detect_config
`define LD_CRITERIA         7
`define LD_LINE_AMP_HI      6
`define LD_LINE_AMP_LO      4
`define LD_TX_AMP_HI        3
`define LD_TX_AMP_LO        2
`define LD_TX_PER_HI        1
`define LD_TX_PER_LO        0

// ==========================================================================
// Field positions, error_count_control
`define EC_EXZ_STD          7
`define EC_VIOL_INS         6
`define EC_SINGLE_ERROR_INSERT          5
`define EC_SRC_HI           4
`define EC_SRC_LO           2
`define EC_UPD_MODE         1
`define EC_UPD_TRIG         0

// ==========================================================================
// Interrupt status bits
`define IRQ_LINE_LOSS       0
`define IRQ_TX_LOSS         1
`define IRQ_COUNT_UPDATE    2
`define IRQ_WIDTH           3

// ==========================================================================
// Pulse-interval counts
`define LINE_LOSS_N_STD     11'd175
`define LINE_LOSS_N_ALT     11'd1544
`define TX_LOSS_N_SHORT     11'd16
`define TX_LOSS_N_MID       11'd32
`define TX_LOSS_N_LONG      11'd64

// ==========================================================================
// Timing
`define CLK_PERIOD_NS       5
`define COUNT_PERIOD_NS     1000000000
`define COUNT_PERIOD_CYCLES (`COUNT_PERIOD_NS / `CLK_PERIOD_NS)

`endif

// ===== hdl/los_pkg.sv
// Types shared by the loss detection and error count block
package los_pkg;

  // ========================================================================
  // Event sources for the error counter
  typedef enum logic [2:0] {
    src_off       = 3'b000,
    src_line_bpv  = 3'b001,
    src_line_exz  = 3'b010,
    src_line_both = 3'b011,
    src_sys_bpv   = 3'b100,
    src_sys_exz   = 3'b101,
    src_sys_both  = 3'b110,
    src_pattern   = 3'b111
  } count_source_e;

  // ========================================================================
  // Bus phase
  typedef enum logic [1:0] {
    ph_idle  = 2'b00,
    ph_write = 2'b01,
    ph_read  = 2'b10
  } bus_phase_e;

  // ========================================================================
  // Strobes and comparator results from the line datapath
  typedef struct packed {
    logic line_pulse;
    logic line_amp_low;
    logic tx_pulse;
    logic tx_amp_low;
    logic tx_mark;
    logic pattern_bit;
    logic line_bipolar_violation;
    logic line_excess_zeros;
    logic system_bipolar_violation;
    logic system_excess_zeros;
    logic pattern_error;
  } link_in_s;

  // ========================================================================
  // Settings and indications toward the datapath
  typedef struct packed {
    logic [1:0] monitor_gain_sel;
    logic       loss_criteria_sel;
    logic [2:0] line_loss_amplitude_sel;
    logic [1:0] tx_loss_amplitude_sel;
    logic       excess_zero_standard_sel;
    logic       line_signal_loss;
    logic       transmit_signal_loss;
    logic       violation_insert_pulse;
    logic       error_insert_pulse;
  } link_out_s;

endpackage : los_pkg

// ===== sim/line_side_model.sv
// Line and framer side model: pulse intervals, marks, pattern bits, events
`timescale 1ns/1ps
module line_side_model (
  // Clock
  input wire logic          hclk,
  // Toward the block
  output los_pkg::link_in_s link_in
);
  initial link_in = '0;
  // ==========================================================================
  // Pulse intervals; amplitude flag inverts outside pulses so it is never trusted
  task automatic pulses(input logic tx, input logic low, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge hclk);
      link_in.tx_pulse <= tx;
      link_in.line_pulse <= ~tx;
      link_in.tx_amp_low <= low;
      link_in.line_amp_low <= low;
      @(posedge hclk);
      link_in.tx_pulse <= 1'b0;
      link_in.line_pulse <= 1'b0;
      link_in.tx_amp_low <= ~low;
      link_in.line_amp_low <= ~low;
    end
  endtask : pulses
  // Late mark or pattern bit, after gap cycles
  task automatic strobe(input logic pat, input int gap);
    repeat (gap) @(posedge hclk);
    link_in.pattern_bit <= pat;
    link_in.tx_mark <= ~pat;
    @(posedge hclk);
    link_in.pattern_bit <= 1'b0;
    link_in.tx_mark <= 1'b0;
  endtask : strobe
  task automatic events(input logic [4:0] ev);
    @(posedge hclk);
    {link_in.line_bipolar_violation, link_in.line_excess_zeros,
     link_in.system_bipolar_violation, link_in.system_excess_zeros,
     link_in.pattern_error} <= ev;
    @(posedge hclk);
    {link_in.line_bipolar_violation, link_in.line_excess_zeros,
     link_in.system_bipolar_violation, link_in.system_excess_zeros,
     link_in.pattern_error} <= 5'h00;
  endtask : events
endmodule : line_side_model

// ===== sim/los_and_error_count_control_sva.sv
// Port-level checks for the loss and error count block
`timescale 1ns/1ps
module los_and_error_count_control_sva (
  // Clock and reset
  input wire logic               hclk,
  input wire logic               hresetn,
  // Bus
  input wire logic               hce,
  input wire logic               hsel,
  input wire logic [1:0]         htrans,
  input wire logic               hwrite,
  input wire logic               hready,
  input wire logic               hreadyout,
  // Line datapath
  input wire los_pkg::link_in_s  link_in,
  input wire los_pkg::link_out_s link_out
);
  default clocking dc @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic take;
  assign take = hce && hsel && hready && htrans[1];
  read_wait_a: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  write_nowait_a: assert property (take && hwrite |=> hreadyout)
    else $error("write stalled");
  tx_clear_a: assert property (link_in.tx_pulse && !link_in.tx_amp_low |=> !link_out.transmit_signal_loss)
    else $error("tx loss not cleared");
  tx_rise_a: assert property ($rose(link_out.transmit_signal_loss) |-> $past(link_in.tx_pulse && link_in.tx_amp_low))
    else $error("tx loss rose without low pulse");
  line_clear_a: assert property (link_in.line_pulse && !link_in.line_amp_low |=> !link_out.line_signal_loss)
    else $error("line loss not cleared");
  line_rise_a: assert property ($rose(link_out.line_signal_loss) |-> $past(link_in.line_pulse && link_in.line_amp_low))
    else $error("line loss rose without low pulse");
  viol_pulse_a: assert property (link_out.violation_insert_pulse |-> $past(link_in.tx_mark) ##1 !link_out.violation_insert_pulse)
    else $error("violation pulse wrong");
  err_pulse_a: assert property (link_out.error_insert_pulse |-> $past(link_in.pattern_bit) ##1 !link_out.error_insert_pulse)
    else $error("error pulse wrong");
endmodule : los_and_error_count_control_sva

bind los_and_error_count_control los_and_error_count_control_sva u_sva (
  .hclk(hclk), .hresetn(hresetn), .hce(hce), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hreadyout(hreadyout), .link_in(link_in), .link_out(link_out));

// ===== sim/los_and_error_count_control_tb_top.sv
// Self-checking bench for the loss and error count block
`timescale 1ns/1ps
`include "los_defs.svh"
module los_and_error_count_control_tb_top;
  logic               hclk, hresetn, hce, hsel, hwrite, hreadyout, hresp, irq;
  logic [1:0]         htrans;
  logic [2:0]         hsize;
  logic [31:0]        haddr, hwdata, hrdata, rdata;
  wire logic          hready;
  los_pkg::link_in_s  link_in;
  los_pkg::link_out_s link_out;
  int                 failures, n_compared;
  assign hready = hreadyout;
  los_and_error_count_control #(.COUNT_PERIOD_CYCLES(50)) DUT (
    .hclk(hclk), .hresetn(hresetn), .hce(hce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .link_in(link_in), .link_out(link_out), .irq(irq));
  line_side_model far (.hclk(hclk), .link_in(link_in));
  // ==========================================================================
  // Helpers
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // Master waits on hready with no assumed latency
  task automatic bus(input logic wr, input logic [5:0] idx, input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= {24'h000000, idx, 2'b00};
    @(posedge hclk);
    while (hreadyout !== 1'b1 && n++ < 40) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h000000, wd};
    @(posedge hclk);
    while (hreadyout !== 1'b1 && n++ < 40) @(posedge hclk);
    rdata = hrdata;
    if (n >= 40) begin
      failures++;
      $display("Error hready expected 1 seen %b", hreadyout);
    end
    @(negedge hclk);
  endtask : bus
  task automatic settle;
    repeat (2) @(negedge hclk);
  endtask : settle
  task automatic wait_irq;
    int n;
    n = 0;
    while (irq !== 1'b0 && n++ < 4) @(negedge hclk);
    while (irq !== 1'b1 && n++ < 120) @(negedge hclk);
    chk("irq raised", 32'h1, {31'h0, irq});
  endtask : wait_irq
  // ==========================================================================
  // Scenarios
  task automatic t_reset;
    logic [5:0] ix [4] = '{`IDX_MONITOR_GAIN, `IDX_LOSS_DETECT, `IDX_ERROR_CONTROL, 6'h3F};
    logic [7:0] ex [4] = '{`RST_MONITOR_GAIN, `RST_LOSS_DETECT, `RST_ERROR_CONTROL, 8'h00};
    chk("link_out", 32'h000000A0, {19'h0, link_out});
    bus(1'b1, 6'h3F, 8'hFF);
    chk("hresp", 32'h0, {31'h0, hresp});
    for (int i = 0; i < 4; i++) begin
      bus(1'b0, ix[i], 8'h00);
      chk("reset value", {24'h0, ex[i]}, rdata);
    end
  endtask : t_reset
  task automatic t_config;
    for (int g = 0; g < 4; g++) begin
      bus(1'b1, `IDX_MONITOR_GAIN, 8'(g));
      chk("monitor_gain_sel", 32'(g), {30'h0, link_out.monitor_gain_sel});
    end
    bus(1'b1, `IDX_LOSS_DETECT, 8'hEB);
    chk("loss fields", 32'h3A, {26'h0, link_out.loss_criteria_sel,
        link_out.line_loss_amplitude_sel, link_out.tx_loss_amplitude_sel});
    bus(1'b0, `IDX_LOSS_DETECT, 8'h00);
    chk("loss_detect_config", 32'hEB, rdata);
    bus(1'b1, `IDX_ERROR_CONTROL, 8'h80);
    chk("excess_zero_standard_sel", 32'h1, {31'h0, link_out.excess_zero_standard_sel});
  endtask : t_config
  task automatic t_tx;
    int n [4] = '{16, 32, 64, 64};
    bus(1'b1, `IDX_IRQ_MASK, 8'h02);
    for (int s = 0; s < 4; s++) begin
      bus(1'b1, `IDX_LOSS_DETECT, 8'h14 | 8'(s));
      far.pulses(1'b1, 1'b1, n[s] - 1);
      settle;
      chk("tx loss early", 32'h0, {31'h0, link_out.transmit_signal_loss});
      far.pulses(1'b1, 1'b1, 1);
      settle;
      chk("tx loss", 32'h1, {31'h0, link_out.transmit_signal_loss});
      chk("irq unmasked", 32'h1, {31'h0, irq});
      bus(1'b1, `IDX_IRQ_STATUS, 8'h02);
      bus(1'b0, `IDX_LOSS_STATUS, 8'h00);
      chk("irq cleared", 32'h0, {31'h0, irq});
      far.pulses(1'b1, 1'b0, 1);
      settle;
      chk("tx loss clear", 32'h0, {31'h0, link_out.transmit_signal_loss});
    end
  endtask : t_tx
  // Clock enable low must freeze the pulse-interval counting
  task automatic t_hold;
    bus(1'b1, `IDX_LOSS_DETECT, 8'h14);
    @(posedge hclk);
    hce <= 1'b0;
    far.pulses(1'b1, 1'b1, 16);
    settle;
    chk("tx loss frozen", 32'h0, {31'h0, link_out.transmit_signal_loss});
    @(posedge hclk);
    hce <= 1'b1;
    far.pulses(1'b1, 1'b1, 16);
    settle;
    chk("tx loss after hold", 32'h1, {31'h0, link_out.transmit_signal_loss});
    far.pulses(1'b1, 1'b0, 1);
    bus(1'b1, `IDX_IRQ_STATUS, 8'h02);
  endtask : t_hold
  task automatic t_line;
    int n [2] = '{175, 1544};
    for (int c = 0; c < 2; c++) begin
      bus(1'b1, `IDX_LOSS_DETECT, c == 0 ? 8'h15 : 8'h95);
      far.pulses(1'b0, 1'b1, n[c] - 1);
      settle;
      chk("line loss early", 32'h0, {31'h0, link_out.line_signal_loss});
      far.pulses(1'b0, 1'b1, 1);
      settle;
      chk("line loss", 32'h1, {31'h0, link_out.line_signal_loss});
      bus(1'b0, `IDX_IRQ_STATUS, 8'h00);
      chk("status bit", 32'h1, rdata & 32'h00000001);
      chk("irq masked", 32'h0, {31'h0, irq});
      bus(1'b1, `IDX_IRQ_STATUS, 8'h01);
      far.pulses(1'b0, 1'b0, 1);
      settle;
      chk("line loss clear", 32'h0, {31'h0, link_out.line_signal_loss});
    end
  endtask : t_line
  task automatic t_insert(input logic err);
    int seen;
    seen = 0;
    bus(1'b1, `IDX_ERROR_CONTROL, err ? 8'h20 : 8'h40);
    bus(1'b0, `IDX_ERROR_CONTROL, 8'h00);
    chk("insert armed", err ? 32'h20 : 32'h40, rdata);
    fork
      far.strobe(err, 6);
      repeat (12) begin
        @(negedge hclk);
        if ((err ? link_out.error_insert_pulse : link_out.violation_insert_pulse) === 1'b1)
          seen++;
      end
    join
    chk("insert pulses", 32'h1, 32'(seen));
    bus(1'b0, `IDX_ERROR_CONTROL, 8'h00);
    chk("insert self clear", 32'h0, rdata);
  endtask : t_insert
  task automatic t_count;
    int ex [8] = '{0, 1, 1, 2, 1, 1, 2, 1};
    for (int c = 0; c < 8; c++) begin
      bus(1'b1, `IDX_ERROR_CONTROL, 8'(c << 2) | 8'h01);
      bus(1'b1, `IDX_ERROR_CONTROL, 8'(c << 2));
      far.events(5'h1F);
      bus(1'b1, `IDX_ERROR_CONTROL, 8'(c << 2) | 8'h01);
      bus(1'b0, `IDX_COUNT_LOW, 8'h00);
      chk("count low", 32'(ex[c]), rdata);
      bus(1'b0, `IDX_COUNT_HIGH, 8'h00);
      chk("count high", 32'h0, rdata);
    end
    far.events(5'h01);
    far.events(5'h01);
    bus(1'b1, `IDX_ERROR_CONTROL, 8'h1D);
    bus(1'b0, `IDX_COUNT_LOW, 8'h00);
    chk("count held", 32'h1, rdata);
    bus(1'b1, `IDX_ERROR_CONTROL, 8'h1C);
    bus(1'b1, `IDX_ERROR_CONTROL, 8'h1D);
    bus(1'b0, `IDX_COUNT_LOW, 8'h00);
    chk("count retrigger", 32'h2, rdata);
  endtask : t_count
  task automatic t_auto;
    bus(1'b1, `IDX_ERROR_CONTROL, 8'h06);
    bus(1'b1, `IDX_IRQ_STATUS, 8'h07);
    bus(1'b1, `IDX_IRQ_MASK, 8'h04);
    wait_irq;
    far.events(5'h10);
    bus(1'b1, `IDX_IRQ_STATUS, 8'h04);
    wait_irq;
    bus(1'b0, `IDX_COUNT_LOW, 8'h00);
    chk("auto count", 32'h1, rdata);
    bus(1'b1, `IDX_IRQ_STATUS, 8'h04);
    wait_irq;
    bus(1'b0, `IDX_COUNT_LOW, 8'h00);
    chk("auto restart", 32'h0, rdata);
  endtask : t_auto
  task automatic close_out;
    $display("Compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : close_out
  // ==========================================================================
  // Clock, sequence, watchdog
  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  initial begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
    hce = 1'b1;
    hsize = 3'b010;
    failures = 0;
    n_compared = 0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(negedge hclk);
    t_reset;
    t_config;
    t_tx;
    t_hold;
    t_line;
    t_insert(1'b0);
    t_insert(1'b1);
    t_count;
    t_auto;
    close_out;
  end
  // Run needs about 4500 cycles
  initial begin
    #100000;
    failures++;
    close_out;
  end
endmodule : los_and_error_count_control_tb_top
